// File: shared/pni_defines.svh
`ifndef PNI_DEFINES_SVH
`define PNI_DEFINES_SVH

// ----------------------------------------
// register word indices
// ----------------------------------------
`define PNI_ADDR_NEAR_W   4'h0
`define PNI_ADDR_DONE_W   4'h1
`define PNI_ADDR_CTRL     4'h2
`define PNI_ADDR_GAIN     4'h3
`define PNI_ADDR_STATUS   4'h4
`define PNI_ADDR_POS_ERR  4'h5
`define PNI_ADDR_TRQ_CMD  4'h6
`define PNI_ADDR_COMMAND  4'h7

// ----------------------------------------
// reset values and ranges
// ----------------------------------------
`define PNI_NEAR_W_RST    32'h4000_0000
`define PNI_NEAR_W_MIN    32'h0000_0001
`define PNI_NEAR_W_MAX    32'h4000_0000
`define PNI_DONE_W_RST    32'h0000_0007
`define PNI_DONE_W_MAX    32'h4000_0000
`define PNI_GAIN_RST      7'h1e
`define PNI_GAIN_MIN      7'h0a
`define PNI_GAIN_MAX      7'h64
`define PNI_METHOD_RST    4'h0

// ----------------------------------------
// control-method field codes
// ----------------------------------------
`define PNI_M_POS         4'h1
`define PNI_M_TRQ         4'h2
`define PNI_M_ISPD_POS    4'h5
`define PNI_M_POS_SPD     4'h7
`define PNI_M_POS_TRQ     4'h8
`define PNI_M_POS_INH     4'hb

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PNI_CTRL_METHOD   3:0
`define PNI_CTRL_ALLOC    4
`define PNI_CTRL_INH_TERM 5
`define PNI_CTRL_NEAR_TERM 6

// ----------------------------------------
// command register fields
// ----------------------------------------
`define PNI_CMD_CLR_HI    0
`define PNI_CMD_CLR_LO    1
`define PNI_CMD_RESTART   2

// ----------------------------------------
// torque scaling and overload timing
// ----------------------------------------
`define PNI_MV_SCALE      20'h0_000a
`define PNI_RATED_PM      20'h0_03e8
`define PNI_HIGH_PM       20'h0_07d0
`define PNI_TRQ_SAT       20'h0_7fff
`define PNI_CLK_KHZ       250000
`define PNI_OVL_HI_MS     100
`define PNI_OVL_LO_MS     10000
`define PNI_DIV_STEPS     5'h14

`endif

// File: shared/pni_pkg.sv
package pni_pkg;
  // active loop selected by control method and select input
  typedef enum logic [1:0] {
    PNI_LOOP_POS,
    PNI_LOOP_SPD,
    PNI_LOOP_ISPD,
    PNI_LOOP_TRQ
  } pni_loop_t;

  // serial divider sequencing
  typedef enum logic {
    PNI_DIV_IDLE,
    PNI_DIV_RUN
  } pni_div_state_t;
endpackage

// File: hw/pni_trq_div.sv
`timescale 1ns/1ps
`include "pni_defines.svh"

module pni_trq_div
  import pni_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // request
  input  wire logic        start,
  input  wire logic [19:0] num,
  input  wire logic [6:0]  den,
  // result
  output logic             done,
  output logic [19:0]      quo
);

  pni_div_state_t state_q;
  logic [19:0]    num_q;
  logic [19:0]    rem_q;
  logic [19:0]    acc_q;
  logic [6:0]     den_q;
  logic [4:0]     step_q;
  logic [20:0]    trial;

  // shift next numerator bit into remainder and test
  assign trial = {rem_q, num_q[19]} - {14'h0000, den_q};

  // restoring division, one quotient bit per cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= PNI_DIV_IDLE;
      num_q   <= 20'h0_0000;
      rem_q   <= 20'h0_0000;
      acc_q   <= 20'h0_0000;
      den_q   <= 7'h00;
      step_q  <= 5'h00;
      quo     <= 20'h0_0000;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        PNI_DIV_IDLE: begin
          if (start) begin
            num_q   <= num;
            den_q   <= den;
            rem_q   <= 20'h0_0000;
            acc_q   <= 20'h0_0000;
            step_q  <= 5'h00;
            state_q <= PNI_DIV_RUN;
          end
        end
        PNI_DIV_RUN: begin
          num_q  <= {num_q[18:0], 1'b0};
          step_q <= step_q + 5'h01;
          if (trial[20]) begin
            rem_q <= {rem_q[18:0], num_q[19]};
            acc_q <= {acc_q[18:0], 1'b0};
          end else begin
            rem_q <= trial[19:0];
            acc_q <= {acc_q[18:0], 1'b1};
          end
          if (step_q == `PNI_DIV_STEPS - 5'h01) begin
            quo     <= trial[20] ? {acc_q[18:0], 1'b0} : {acc_q[18:0], 1'b1};
            done    <= 1'b1;
            state_q <= PNI_DIV_IDLE;
          end
        end
        default: state_q <= PNI_DIV_IDLE;
      endcase
    end
  end

endmodule

// File: hw/pni_position_near.sv
`timescale 1ns/1ps
`include "pni_defines.svh"

// Overview of operation
// RL1: near output on while position error is below near-window width.
// RL2: near width accepts 1 to 1073741824, resets to 1073741824, applies at once.
// RL3: outputs high (closed) near completion, low (open) otherwise.
// RL4: near output drives terminal only when its output allocation is set.
// RL5: software should program near width larger than done width.
// RL6: inhibit active in position control drops incoming reference pulses.
// RL7: allocation mode 0 inhibits only in method B, from proportional input.
// RL8: in that mode, proportional input on stops counting, off counts.
// RL9: in method B the proportional input serves inhibit only.
// RL10: allocation mode 1 takes inhibit from dedicated input, on stops counting.
// RL11: dedicated inhibit acts only in methods 1,5,7,8 and when allocated.
// RL12: method 5 switches internal set speed and position by control select.
// RL13: inhibit only during position control, not speed or torque phases.
// RL14: method 2 selects torque control; method changes apply after restart.
// RL15: torque gain accepts 10 to 100 in 0.1 V per rated torque, immediate.
// RL16: torque gain resets to 30, rated torque at 3.0 V.
// RL17: torque command proportional to input voltage, sign gives direction.
// RL18: over-rated torque allowed; persistent excess raises high or low load alarm.
// RL19: done output on while absolute position error is below done width.
// RL20: near compare uses absolute error, same in both directions.
// RL21: feedback keeps updating the error while reference counting is inhibited.
module pni_position_near
  import pni_pkg::*;
#(
  parameter int OVL_HI_CYC = `PNI_OVL_HI_MS * `PNI_CLK_KHZ,
  parameter logic [31:0] OVL_LO_CYC = 32'(`PNI_OVL_LO_MS) * 32'(`PNI_CLK_KHZ)
)(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  // reference and feedback pulses
  input  wire logic               ref_pulse_in,
  input  wire logic               ref_dir_in,
  input  wire logic               fb_pulse_in,
  input  wire logic               fb_dir_in,
  // sequence inputs, high means closed
  input  wire logic               proportional_ctrl_in,
  input  wire logic               inhibit_in,
  input  wire logic               control_select_in,
  input  wire logic               speed_select_a_in,
  input  wire logic               speed_select_b_in,
  input  wire logic               speed_direction_in,
  // analog torque reference, signed millivolts
  input  wire logic signed [15:0] torque_ref_mv,
  // status outputs, high means closed
  output logic                    near_out,
  output logic                    position_done_out,
  output logic                    p_ctrl_req_out,
  output logic [1:0]              loop_out,
  output logic [2:0]              speed_sel_out,
  output logic signed [15:0]      torque_cmd_out,
  output logic                    ovl_high_alarm_out,
  output logic                    ovl_low_alarm_out
);

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  logic [31:0]        near_window_width_q;
  logic [31:0]        done_window_width_q;
  logic [3:0]         control_method_field_q;
  logic               input_allocation_mode_q;
  logic               block_input_allocation_q;
  logic               near_output_allocation_q;
  logic [6:0]         torque_input_gain_q;
  logic [3:0]         method_act_q;

  logic               wr_near;
  logic               wr_done;
  logic               wr_ctrl;
  logic               wr_gain;
  logic               wr_cmd;

  assign wr_near = reg_wr && (reg_addr == `PNI_ADDR_NEAR_W);
  assign wr_done = reg_wr && (reg_addr == `PNI_ADDR_DONE_W);
  assign wr_ctrl = reg_wr && (reg_addr == `PNI_ADDR_CTRL);
  assign wr_gain = reg_wr && (reg_addr == `PNI_ADDR_GAIN);
  assign wr_cmd  = reg_wr && (reg_addr == `PNI_ADDR_COMMAND);

  // near width, clamped into its range, live at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      near_window_width_q <= `PNI_NEAR_W_RST; // RL2
    end else if (wr_near) begin
      if (reg_wdata < `PNI_NEAR_W_MIN) begin
        near_window_width_q <= `PNI_NEAR_W_MIN; // RL2
      end else if (reg_wdata > `PNI_NEAR_W_MAX) begin
        near_window_width_q <= `PNI_NEAR_W_MAX; // RL2
      end else begin
        near_window_width_q <= reg_wdata; // RL2
      end
    end
  end

  // done width, clamped to its top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_window_width_q <= `PNI_DONE_W_RST;
    end else if (wr_done) begin
      done_window_width_q <= (reg_wdata > `PNI_DONE_W_MAX) ? `PNI_DONE_W_MAX : reg_wdata;
    end
  end

  // method field and allocation bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_method_field_q   <= `PNI_METHOD_RST;
      input_allocation_mode_q  <= 1'b0;
      block_input_allocation_q <= 1'b0;
      near_output_allocation_q <= 1'b0;
    end else if (wr_ctrl) begin
      control_method_field_q   <= reg_wdata[`PNI_CTRL_METHOD];
      input_allocation_mode_q  <= reg_wdata[`PNI_CTRL_ALLOC];
      block_input_allocation_q <= reg_wdata[`PNI_CTRL_INH_TERM];
      near_output_allocation_q <= reg_wdata[`PNI_CTRL_NEAR_TERM];
    end
  end

  // method in force changes only on a restart command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      method_act_q <= `PNI_METHOD_RST;
    end else if (wr_cmd && reg_wdata[`PNI_CMD_RESTART]) begin
      method_act_q <= control_method_field_q; // RL14
    end
  end

  // torque gain, clamped, live at once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torque_input_gain_q <= `PNI_GAIN_RST; // RL16
    end else if (wr_gain) begin
      if (reg_wdata < 32'(`PNI_GAIN_MIN)) begin
        torque_input_gain_q <= `PNI_GAIN_MIN; // RL15
      end else if (reg_wdata > 32'(`PNI_GAIN_MAX)) begin
        torque_input_gain_q <= `PNI_GAIN_MAX; // RL15
      end else begin
        torque_input_gain_q <= reg_wdata[6:0]; // RL15
      end
    end
  end

  // ----------------------------------------
  // loop selection
  // ----------------------------------------
  pni_loop_t loop;
  logic      pos_active;

  // pick active loop from method in force and control select
  always_comb begin
    case (method_act_q)
      `PNI_M_TRQ:      loop = PNI_LOOP_TRQ; // RL14
      `PNI_M_ISPD_POS: loop = control_select_in ? PNI_LOOP_POS : PNI_LOOP_ISPD; // RL12
      `PNI_M_POS_SPD:  loop = control_select_in ? PNI_LOOP_SPD : PNI_LOOP_POS;
      `PNI_M_POS_TRQ:  loop = control_select_in ? PNI_LOOP_TRQ : PNI_LOOP_POS;
      `PNI_M_POS:      loop = PNI_LOOP_POS;
      `PNI_M_POS_INH:  loop = PNI_LOOP_POS;
      default:         loop = PNI_LOOP_SPD;
    endcase
  end

  assign pos_active = (loop == PNI_LOOP_POS);

  // ----------------------------------------
  // pulse inhibit
  // ----------------------------------------
  logic inh_method_ok;
  logic inh_req;
  logic inh_active;

  // methods that honour the dedicated inhibit input
  assign inh_method_ok = (method_act_q == `PNI_M_POS) || (method_act_q == `PNI_M_ISPD_POS) ||
                         (method_act_q == `PNI_M_POS_SPD) || (method_act_q == `PNI_M_POS_TRQ);

  // inhibit source by allocation mode
  always_comb begin
    if (!input_allocation_mode_q) begin
      inh_req = (method_act_q == `PNI_M_POS_INH) && proportional_ctrl_in; // RL7 RL8
    end else begin
      inh_req = inh_method_ok && block_input_allocation_q && inhibit_in; // RL10 RL11
    end
  end

  assign inh_active = inh_req && pos_active; // RL13

  // proportional request suppressed when the input serves inhibit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p_ctrl_req_out <= 1'b0;
    end else begin
      p_ctrl_req_out <= proportional_ctrl_in && (method_act_q != `PNI_M_POS_INH); // RL9
    end
  end

  // ----------------------------------------
  // position error
  // ----------------------------------------
  logic signed [31:0] err_q;
  logic signed [31:0] ref_step;
  logic signed [31:0] fb_step;
  logic [31:0]        err_abs;

  // reference step dropped while inhibited, feedback always applied
  always_comb begin
    ref_step = 32'sh0000_0000;
    fb_step  = 32'sh0000_0000;
    if (ref_pulse_in && pos_active && !inh_active) begin // RL6
      ref_step = ref_dir_in ? -32'sh0000_0001 : 32'sh0000_0001;
    end
    if (fb_pulse_in) begin // RL21
      fb_step = fb_dir_in ? -32'sh0000_0001 : 32'sh0000_0001;
    end
  end

  // error counter clears outside position control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 32'sh0000_0000;
    end else if (!pos_active) begin
      err_q <= 32'sh0000_0000;
    end else begin
      err_q <= err_q + ref_step - fb_step; // RL21
    end
  end

  assign err_abs = err_q[31] ? 32'(-err_q) : 32'(err_q); // RL20

  // near and done compares, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      near_out          <= 1'b0;
      position_done_out <= 1'b0;
    end else begin
      near_out          <= near_output_allocation_q && pos_active &&
                           (err_abs < near_window_width_q); // RL1 RL3 RL4 RL20
      position_done_out <= pos_active && (err_abs < done_window_width_q); // RL19 RL3
    end
  end

  // ----------------------------------------
  // speed select and loop status
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_out      <= 2'h0;
      speed_sel_out <= 3'h0;
    end else begin
      loop_out      <= loop;
      speed_sel_out <= (loop == PNI_LOOP_ISPD) ?
                       {speed_direction_in, speed_select_b_in, speed_select_a_in} : 3'h0; // RL12
    end
  end

  // ----------------------------------------
  // torque scaling, per mille of rated
  // ----------------------------------------
  logic        div_done;
  logic [19:0] div_quo;
  logic [19:0] mv_mag;
  logic        sign_q;
  logic        sign_run_q;
  logic        div_busy_q;

  assign mv_mag = {4'h0, torque_ref_mv[15] ? 16'(-torque_ref_mv) : 16'(torque_ref_mv)};

  // permille = mv * 10 / gain
  pni_trq_div u_div (
    .clk   (clk),
    .rst   (rst),
    .start (!div_busy_q),
    .num   (20'(mv_mag * `PNI_MV_SCALE)),
    .den   (torque_input_gain_q),
    .done  (div_done),
    .quo   (div_quo)
  );

  // track divider activity and sign of the sample in flight
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_busy_q <= 1'b0;
      sign_run_q <= 1'b0;
      sign_q     <= 1'b0;
    end else if (!div_busy_q) begin
      div_busy_q <= 1'b1;
      sign_run_q <= torque_ref_mv[15];
    end else if (div_done) begin
      div_busy_q <= 1'b0;
      sign_q     <= sign_run_q;
    end
  end

  logic [19:0] trq_mag_q;

  // signed command, saturated, only in torque loop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trq_mag_q      <= 20'h0_0000;
      torque_cmd_out <= 16'sh0000;
    end else begin
      if (div_done) begin
        trq_mag_q <= div_quo;
      end
      if (loop != PNI_LOOP_TRQ) begin
        torque_cmd_out <= 16'sh0000; // RL14
      end else if (div_done && div_quo > `PNI_TRQ_SAT) begin
        torque_cmd_out <= sign_run_q ? -16'sh7fff : 16'sh7fff; // RL17
      end else if (div_done) begin
        torque_cmd_out <= sign_run_q ? -16'(div_quo) : 16'(div_quo); // RL17
      end
    end
  end

  // ----------------------------------------
  // overload timing
  // ----------------------------------------
  logic [31:0] hi_cnt_q;
  logic [31:0] lo_cnt_q;
  logic        over_hi;
  logic        over_rated;

  assign over_hi    = (loop == PNI_LOOP_TRQ) && (trq_mag_q > `PNI_HIGH_PM);
  assign over_rated = (loop == PNI_LOOP_TRQ) && (trq_mag_q > `PNI_RATED_PM);

  // excess durations, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hi_cnt_q <= 32'h0000_0000;
      lo_cnt_q <= 32'h0000_0000;
    end else begin
      hi_cnt_q <= !over_hi ? 32'h0000_0000 :
                  (hi_cnt_q < 32'(OVL_HI_CYC)) ? hi_cnt_q + 32'h0000_0001 : hi_cnt_q;
      lo_cnt_q <= !over_rated ? 32'h0000_0000 :
                  (lo_cnt_q < 32'(OVL_LO_CYC)) ? lo_cnt_q + 32'h0000_0001 : lo_cnt_q;
    end
  end

  // sticky alarms, set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovl_high_alarm_out <= 1'b0;
      ovl_low_alarm_out  <= 1'b0;
    end else begin
      if (hi_cnt_q >= 32'(OVL_HI_CYC)) begin
        ovl_high_alarm_out <= 1'b1; // RL18
      end else if (wr_cmd && reg_wdata[`PNI_CMD_CLR_HI]) begin
        ovl_high_alarm_out <= 1'b0;
      end
      if (lo_cnt_q >= 32'(OVL_LO_CYC)) begin
        ovl_low_alarm_out <= 1'b1; // RL18
      end else if (wr_cmd && reg_wdata[`PNI_CMD_CLR_LO]) begin
        ovl_low_alarm_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register read
  // ----------------------------------------
  logic [31:0] rd_mux;

  always_comb begin
    case (reg_addr)
      `PNI_ADDR_NEAR_W:  rd_mux = near_window_width_q;
      `PNI_ADDR_DONE_W:  rd_mux = done_window_width_q;
      `PNI_ADDR_CTRL:    rd_mux = {25'h000_0000, near_output_allocation_q,
                                   block_input_allocation_q, input_allocation_mode_q,
                                   control_method_field_q};
      `PNI_ADDR_GAIN:    rd_mux = {25'h000_0000, torque_input_gain_q};
      `PNI_ADDR_STATUS:  rd_mux = {20'h0_0000, method_act_q, 1'b0, ovl_low_alarm_out,
                                   ovl_high_alarm_out, loop_out, inh_active,
                                   position_done_out, near_out};
      `PNI_ADDR_POS_ERR: rd_mux = err_q;
      `PNI_ADDR_TRQ_CMD: rd_mux = {{16{torque_cmd_out[15]}}, torque_cmd_out};
      default:           rd_mux = 32'h0000_0000;
    endcase
  end

  // read data stand one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

// File: sim/pni_host_model.sv
`timescale 1ns/1ps

// host pulse train source
module pni_host_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // train request
  input  wire logic       go,
  input  wire logic [7:0] count,
  input  wire logic       dir,
  // pulse lines
  output logic            pulse,
  output logic            dir_out,
  output logic            busy
);
  logic [7:0] left_q;

  assign busy = (left_q != 8'h00) || pulse;

  // pulse counter, low cycle between pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_q <= 8'h00;
      pulse  <= 1'b0;
    end else if (go) begin
      left_q <= count;
    end else begin
      pulse <= (left_q != 8'h00) && !pulse;
      if ((left_q != 8'h00) && !pulse) begin
        left_q <= left_q - 8'h01;
      end
    end
  end

  // direction holds in a train, toggles while idle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_out <= 1'b0;
    end else begin
      dir_out <= go ? dir : (busy ? dir_out : ~dir_out);
    end
  end
endmodule

// File: sim/pni_position_near_props.sv
`timescale 1ns/1ps
`include "pni_defines.svh"

module pni_position_near_props
  import pni_pkg::*;
(
  // clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // register port
  input wire logic [3:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [31:0]        reg_rdata,
  // status outputs
  input wire logic               near_out,
  input wire logic               position_done_out,
  input wire logic [1:0]         loop_out,
  input wire logic [2:0]         speed_sel_out,
  input wire logic signed [15:0] torque_cmd_out,
  input wire logic               ovl_high_alarm_out,
  input wire logic               ovl_low_alarm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // alarm clear commands
  logic clr_hi;
  logic clr_lo;
  assign clr_hi = reg_wr && reg_addr == `PNI_ADDR_COMMAND && reg_wdata[`PNI_CMD_CLR_HI];
  assign clr_lo = reg_wr && reg_addr == `PNI_ADDR_COMMAND && reg_wdata[`PNI_CMD_CLR_LO];

  near_pos_a: assert property (
    near_out |-> loop_out == PNI_LOOP_POS)
    else $error("near outside position loop");
  done_pos_a: assert property (
    position_done_out |-> loop_out == PNI_LOOP_POS)
    else $error("done outside position loop");
  speed_sel_a: assert property (
    speed_sel_out != 3'h0 |-> loop_out == PNI_LOOP_ISPD)
    else $error("speed select outside speed loop");
  torque_loop_a: assert property (
    torque_cmd_out != 16'h0000 |-> loop_out == PNI_LOOP_TRQ)
    else $error("torque outside torque loop");
  hi_clear_a: assert property (
    $fell(ovl_high_alarm_out) |-> $past(clr_hi))
    else $error("high alarm dropped unasked");
  lo_clear_a: assert property (
    $fell(ovl_low_alarm_out) |-> $past(clr_lo))
    else $error("low alarm dropped unasked");
  rd_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  status_rd_a: assert property (
    reg_rd && reg_addr == `PNI_ADDR_STATUS |=>
      reg_rdata[1:0] == {$past(position_done_out), $past(near_out)} &&
      reg_rdata[4:3] == $past(loop_out))
    else $error("status word mismatch");
  torque_rd_a: assert property (
    reg_rd && reg_addr == `PNI_ADDR_TRQ_CMD |=> reg_rdata[15:0] == $past(torque_cmd_out))
    else $error("torque readback mismatch");
endmodule

bind pni_position_near pni_position_near_props u_props (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .near_out,
  .position_done_out, .loop_out, .speed_sel_out, .torque_cmd_out,
  .ovl_high_alarm_out, .ovl_low_alarm_out);

// File: sim/tb_position_near_and_pulse_inhibit.sv
`timescale 1ns/1ps
`include "pni_defines.svh"

module tb_position_near_and_pulse_inhibit;
  import pni_pkg::*;

  logic               clk = 1'b0, rst = 1'b1;
  logic [3:0]         reg_addr = 4'h0;
  logic [31:0]        reg_wdata = 32'h0000_0000, reg_rdata, v;
  logic               reg_wr = 1'b0, reg_rd = 1'b0;
  logic               ref_go = 1'b0, fb_go = 1'b0, host_d = 1'b0;
  logic [7:0]         host_n = 8'h00;
  logic               ref_p, ref_d, ref_busy, fb_p, fb_d, fb_busy;
  logic               prop = 1'b0, inh = 1'b0, csel = 1'b0;
  logic               spa = 1'b0, spb = 1'b0, spd = 1'b0;
  logic signed [15:0] mv = 16'sh0000, tcmd;
  logic               near, done, preq, ahi, alo;
  logic [1:0]         loop;
  logic [2:0]         ssel;
  int                 n_mismatch = 0, checks = 0, cyc = 0;

  always #2 clk = ~clk;

  pni_host_model ref_u (.clk(clk), .rst(rst), .go(ref_go), .count(host_n), .dir(host_d),
    .pulse(ref_p), .dir_out(ref_d), .busy(ref_busy));
  pni_host_model fb_u (.clk(clk), .rst(rst), .go(fb_go), .count(host_n), .dir(host_d),
    .pulse(fb_p), .dir_out(fb_d), .busy(fb_busy));

  pni_position_near #(.OVL_HI_CYC(50), .OVL_LO_CYC(100)) dut_u (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ref_pulse_in(ref_p),
    .ref_dir_in(ref_d),
    .fb_pulse_in(fb_p), .fb_dir_in(fb_d), .proportional_ctrl_in(prop), .inhibit_in(inh),
    .control_select_in(csel), .speed_select_a_in(spa), .speed_select_b_in(spb),
    .speed_direction_in(spd), .torque_ref_mv(mv), .near_out(near),
    .position_done_out(done), .p_ctrl_req_out(preq), .loop_out(loop),
    .speed_sel_out(ssel), .torque_cmd_out(tcmd), .ovl_high_alarm_out(ahi),
    .ovl_low_alarm_out(alo));

  task automatic end_of_test;
    if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    w(1);
    reg_wr <= 1'b0;
    w(1);
  endtask

  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    w(1);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    w(1);
  endtask

  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(v, e);
  endtask

  task automatic mode(input logic [31:0] c);
    wr(`PNI_ADDR_CTRL, c);
    wr(`PNI_ADDR_COMMAND, 32'h0000_0004);
    w(3);
  endtask

  task automatic send(input logic fb, input logic [7:0] n, input logic d);
    host_n <= n;
    host_d <= d;
    if (fb) fb_go <= 1'b1;
    else ref_go <= 1'b1;
    w(1);
    {ref_go, fb_go} <= 2'b00;
    w(1);
    while (ref_busy || fb_busy) w(1);
    w(4);
  endtask

  task automatic err_is(input logic [31:0] e);
    rc(`PNI_ADDR_POS_ERR, e);
  endtask

  task automatic t_regs;
    rc(`PNI_ADDR_NEAR_W, `PNI_NEAR_W_RST);
    rc(`PNI_ADDR_GAIN, 32'h0000_001e);
    rc(4'hf, 32'h0000_0000);
    chk(32'(loop), 32'(PNI_LOOP_SPD));
    wr(`PNI_ADDR_NEAR_W, 32'h0000_0000);
    rc(`PNI_ADDR_NEAR_W, `PNI_NEAR_W_MIN);
    wr(`PNI_ADDR_NEAR_W, 32'h8000_0000);
    rc(`PNI_ADDR_NEAR_W, `PNI_NEAR_W_MAX);
  endtask

  task automatic t_near;
    mode(32'h0000_0041);
    wr(`PNI_ADDR_DONE_W, 32'h0000_0002);
    wr(`PNI_ADDR_NEAR_W, 32'h0000_0004);
    w(3);
    chk({near, done}, 2'b11);
    send(1'b0, 8'h03, 1'b0);
    chk({near, done}, 2'b10);
    send(1'b0, 8'h01, 1'b0);
    chk(near, 1'b0);
    send(1'b1, 8'h04, 1'b0);
    chk({near, done}, 2'b11);
    send(1'b0, 8'h04, 1'b1);
    err_is(32'hffff_fffc);
    chk(near, 1'b0);
    send(1'b0, 8'h01, 1'b0);
    chk(near, 1'b1);
    send(1'b0, 8'h03, 1'b0);
    mode(32'h0000_0001);
    chk({near, done}, 2'b01);
  endtask

  task automatic t_inhibit;
    mode(32'h0000_000b);
    prop <= 1'b1;
    send(1'b0, 8'h05, 1'b0);
    err_is(32'h0000_0000);
    chk(preq, 1'b0);
    prop <= 1'b0;
    send(1'b0, 8'h02, 1'b0);
    err_is(32'h0000_0002);
    prop <= 1'b1;
    send(1'b1, 8'h02, 1'b0);
    err_is(32'h0000_0000);
    mode(32'h0000_0031);
    inh <= 1'b1;
    send(1'b0, 8'h03, 1'b0);
    err_is(32'h0000_0000);
    chk(preq, 1'b1);
    inh <= 1'b0;
    send(1'b0, 8'h03, 1'b0);
    err_is(32'h0000_0003);
    mode(32'h0000_0011);
    inh <= 1'b1;
    send(1'b0, 8'h02, 1'b0);
    err_is(32'h0000_0005);
  endtask

  task automatic t_methods;
    logic [3:0] m [4] = '{4'h1, 4'h5, 4'h7, 4'h8};
    logic [1:0] e [8] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    int i;
    mode(32'h0000_0000);
    {spd, spb, spa} <= 3'b101;
    for (i = 0; i < 8; i++) begin
      csel <= i[2];
      mode({28'h000_0003, m[i[1:0]]});
      chk(32'(loop), 32'(e[i]));
      chk(32'(ssel), (e[i] == 2'h2) ? 32'h5 : 32'h0);
      send(1'b0, 8'h02, 1'b0);
      err_is(32'h0000_0000);
    end
  endtask

  task automatic t_torque;
    mode(32'h0000_0002);
    chk(32'(loop), 32'(PNI_LOOP_TRQ));
    wr(`PNI_ADDR_CTRL, 32'h0000_0001);
    mv <= 16'sd3000;
    w(60);
    chk(32'(loop), 32'(PNI_LOOP_TRQ));
    chk(32'(tcmd), 32'h0000_03e8);
    rd(`PNI_ADDR_TRQ_CMD);
    mv <= -16'sd1500;
    w(60);
    chk(32'(tcmd), 32'hffff_fe0c);
    wr(`PNI_ADDR_GAIN, 32'h0000_0064);
    mv <= 16'sd3000;
    w(60);
    chk(32'(tcmd), 32'h0000_012c);
    wr(`PNI_ADDR_GAIN, 32'h0000_0005);
    rc(`PNI_ADDR_GAIN, 32'h0000_000a);
    mv <= 16'sd2100;
    w(300);
    chk({ahi, alo}, 2'b11);
    rd(`PNI_ADDR_STATUS);
    mv <= 16'sd0;
    w(60);
    wr(`PNI_ADDR_COMMAND, 32'h0000_0003);
    w(3);
    chk({ahi, alo}, 2'b00);
  endtask

  // cycle ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // test sequence
  initial begin
    w(20);
    rst <= 1'b0;
    w(1);
    t_regs();
    t_near();
    t_inhibit();
    t_methods();
    t_torque();
    end_of_test();
  end
endmodule
